// *** src/uoxb_ctrl.v ***
// Purpose: OUT endpoint X buffer descriptor and receive control
// Assumes: packet strobes come from the serial engine on the same clock
// Notes: register reads answer one cycle after the read strobe
`include "uoxb_consts.vh"

module uoxb_ctrl #(
    parameter ADDR_W = 11,
    parameter CNT_W = 7
) (
    // clock and reset
    input wire ref_clk_in,
    input wire rst_in,
    // register port
    input wire [2:0] reg_addr_in,
    input wire [7:0] reg_wdata_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    output wire [7:0] reg_rdata_out,
    // packet side from the serial engine
    input wire pkt_start_in,
    input wire byte_valid_in,
    input wire [7:0] byte_in,
    input wire pkt_ok_in,
    input wire pkt_err_in,
    // handshake answer
    output wire ack_out,
    output wire nak_out,
    // buffer memory write port
    output wire mem_we_out,
    output wire [ADDR_W-1:0] mem_addr_out,
    output wire [7:0] mem_data_out,
    // status
    output wire buffer_full_out,
    output wire iso_mode_out,
    output wire [ADDR_W-1:0] x_start_out,
    output wire [ADDR_W-1:0] y_start_out,
    output wire irq_out
);

    localparam ST_IDLE = `UOXB_ST_IDLE;
    localparam ST_RECV = `UOXB_ST_RECV;
    localparam ST_DROP = `UOXB_ST_DROP;

    // software registers
    reg [7:0] cfg_q;
    reg buffer_full_flag_q;
    reg [CNT_W-1:0] x_received_count_q;
    reg [7:0] buffer_size_units_q;
    reg [7:0] x_start_address_high_q;
    reg [7:0] y_start_address_high_q;
    reg [1:0] int_status_q;
    reg [1:0] int_mask_q;
    reg [7:0] rdata_q;

    // receive datapath
    reg [1:0] state_q;
    reg [1:0] state_d;
    reg [ADDR_W-1:0] off_q;
    reg [ADDR_W-1:0] off_d;
    reg [CNT_W-1:0] bytes_q;
    reg [CNT_W-1:0] bytes_d;
    reg [CNT_W-1:0] samples_q;
    reg [CNT_W-1:0] samples_d;
    reg [1:0] sub_q;
    reg [1:0] sub_d;
    reg ack_q;
    reg nak_q;
    reg mem_we_q;
    reg [ADDR_W-1:0] mem_addr_q;
    reg [7:0] mem_data_q;
    reg full_out_q;
    reg iso_out_q;
    reg [ADDR_W-1:0] x_start_q;
    reg [ADDR_W-1:0] y_start_q;
    reg irq_q;

    // combinational controls
    reg set_full;
    reg rx_event;
    reg nak_event;
    reg wr_byte;
    reg [ADDR_W-1:0] wr_addr;

    wire iso_mode = cfg_q[`UOXB_ISO_BIT];
    wire [1:0] bps_code = cfg_q[`UOXB_BPS_MSB:`UOXB_BPS_LSB];
    // base byte supplies bits 10:3, low bits tied to zero
    wire [ADDR_W-1:0] x_start = {x_start_address_high_q, `UOXB_LOW_ZERO};
    wire [ADDR_W-1:0] y_start = {y_start_address_high_q, `UOXB_LOW_ZERO};
    // size in 8-byte units, one buffer of each pair or the whole ring
    wire [ADDR_W-1:0] capacity = {buffer_size_units_q, `UOXB_LOW_ZERO};
    wire [ADDR_W-1:0] off_next = off_q + {{(ADDR_W-1){1'b0}}, 1'b1};

    wire wr_count = reg_wr_in && (reg_addr_in == `UOXB_REG_COUNT_STATUS);
    wire rd_status = reg_rd_in && (reg_addr_in == `UOXB_REG_INT_STATUS);

    always @*
    begin
        state_d = state_q;
        off_d = off_q;
        bytes_d = bytes_q;
        samples_d = samples_q;
        sub_d = sub_q;
        set_full = 1'b0;
        rx_event = 1'b0;
        nak_event = 1'b0;
        wr_byte = 1'b0;
        wr_addr = x_start + off_q;
        case (state_q)
            ST_IDLE:
            begin
                if (pkt_start_in)
                begin
                    off_d = {ADDR_W{1'b0}};
                    bytes_d = {CNT_W{1'b0}};
                    samples_d = {CNT_W{1'b0}};
                    sub_d = 2'h0;
                    // busy buffer refuses unless isochronous
                    if (buffer_full_flag_q && !iso_mode)
                    begin
                        state_d = ST_DROP;
                    end
                    else
                    begin
                        state_d = ST_RECV;
                    end
                end
            end
            ST_RECV:
            begin
                if (pkt_err_in)
                begin
                    state_d = ST_IDLE;
                end
                else if (pkt_ok_in)
                begin
                    state_d = ST_IDLE;
                    set_full = 1'b1;
                    rx_event = 1'b1;
                end
                else if (byte_valid_in)
                begin
                    bytes_d = bytes_q + {{(CNT_W-1){1'b0}}, 1'b1};
                    if (sub_q == bps_code)
                    begin
                        sub_d = 2'h0;
                        samples_d = samples_q + {{(CNT_W-1){1'b0}}, 1'b1};
                    end
                    else
                    begin
                        sub_d = sub_q + 2'h1;
                    end
                    if (iso_mode)
                    begin
                        // ring: every byte lands, offset folds at the end
                        wr_byte = 1'b1;
                        if (off_next >= capacity)
                        begin
                            off_d = {ADDR_W{1'b0}};
                        end
                        else
                        begin
                            off_d = off_next;
                        end
                    end
                    else if (off_q < capacity)
                    begin
                        // overflow bytes dropped to protect the Y buffer
                        wr_byte = 1'b1;
                        off_d = off_next;
                    end
                end
            end
            ST_DROP:
            begin
                if (pkt_ok_in || pkt_err_in)
                begin
                    state_d = ST_IDLE;
                    nak_event = 1'b1;
                end
            end
            default:
            begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            state_q <= ST_IDLE;
            off_q <= {ADDR_W{1'b0}};
            bytes_q <= {CNT_W{1'b0}};
            samples_q <= {CNT_W{1'b0}};
            sub_q <= 2'h0;
            ack_q <= 1'b0;
            nak_q <= 1'b0;
            mem_we_q <= 1'b0;
            mem_addr_q <= {ADDR_W{1'b0}};
            mem_data_q <= `UOXB_RST_BYTE;
        end
        else
        begin
            state_q <= state_d;
            off_q <= off_d;
            bytes_q <= bytes_d;
            samples_q <= samples_d;
            sub_q <= sub_d;
            // isochronous packets get no handshake at all
            ack_q <= rx_event && !iso_mode;
            nak_q <= nak_event && !iso_mode;
            mem_we_q <= wr_byte;
            mem_addr_q <= wr_addr;
            mem_data_q <= byte_in;
        end
    end

    // descriptor bytes
    always @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            cfg_q <= `UOXB_RST_BYTE;
            buffer_full_flag_q <= 1'b0;
            x_received_count_q <= {CNT_W{1'b0}};
            buffer_size_units_q <= `UOXB_RST_BYTE;
            x_start_address_high_q <= `UOXB_RST_BYTE;
            y_start_address_high_q <= `UOXB_RST_BYTE;
            int_mask_q <= 2'h0;
        end
        else
        begin
            if (reg_wr_in && (reg_addr_in == `UOXB_REG_CONFIG))
            begin
                cfg_q <= reg_wdata_in;
            end
            if (reg_wr_in && (reg_addr_in == `UOXB_REG_BUFFER_SIZE))
            begin
                buffer_size_units_q <= reg_wdata_in;
            end
            if (reg_wr_in && (reg_addr_in == `UOXB_REG_X_BASE))
            begin
                x_start_address_high_q <= reg_wdata_in;
            end
            if (reg_wr_in && (reg_addr_in == `UOXB_REG_Y_BASE))
            begin
                y_start_address_high_q <= reg_wdata_in;
            end
            if (reg_wr_in && (reg_addr_in == `UOXB_REG_INT_MASK))
            begin
                int_mask_q <= reg_wdata_in[1:0];
            end
            // a packet ending beside a software write wins the byte
            if (set_full)
            begin
                buffer_full_flag_q <= 1'b1;
                if (iso_mode)
                begin
                    x_received_count_q <= samples_d;
                end
                else
                begin
                    x_received_count_q <= bytes_d;
                end
            end
            else if (wr_count)
            begin
                buffer_full_flag_q <= reg_wdata_in[`UOXB_FULL_BIT];
                x_received_count_q <= reg_wdata_in[CNT_W-1:0];
            end
        end
    end

    // sticky events, cleared by reading them; a new event beats the clear
    always @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            int_status_q <= 2'h0;
        end
        else
        begin
            int_status_q[`UOXB_INT_RX_BIT] <= rx_event ||
                (int_status_q[`UOXB_INT_RX_BIT] && !rd_status);
            int_status_q[`UOXB_INT_NAK_BIT] <= (nak_event && !iso_mode) ||
                (int_status_q[`UOXB_INT_NAK_BIT] && !rd_status);
        end
    end

    // read data stands only in the cycle after the strobe
    always @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            rdata_q <= `UOXB_RST_BYTE;
        end
        else if (reg_rd_in)
        begin
            case (reg_addr_in)
                `UOXB_REG_CONFIG: rdata_q <= cfg_q;
                `UOXB_REG_COUNT_STATUS: rdata_q <= {buffer_full_flag_q, x_received_count_q};
                `UOXB_REG_BUFFER_SIZE: rdata_q <= buffer_size_units_q;
                `UOXB_REG_X_BASE: rdata_q <= x_start_address_high_q;
                `UOXB_REG_Y_BASE: rdata_q <= y_start_address_high_q;
                `UOXB_REG_INT_STATUS: rdata_q <= {6'h00, int_status_q};
                `UOXB_REG_INT_MASK: rdata_q <= {6'h00, int_mask_q};
                default: rdata_q <= `UOXB_RST_BYTE;
            endcase
        end
        else
        begin
            rdata_q <= `UOXB_RST_BYTE;
        end
    end

    // status outputs registered once more; they trail the bytes by a cycle
    always @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            full_out_q <= 1'b0;
            iso_out_q <= 1'b0;
            x_start_q <= {ADDR_W{1'b0}};
            y_start_q <= {ADDR_W{1'b0}};
            irq_q <= 1'b0;
        end
        else
        begin
            full_out_q <= buffer_full_flag_q;
            iso_out_q <= iso_mode;
            x_start_q <= x_start;
            y_start_q <= y_start;
            irq_q <= |(int_status_q & int_mask_q);
        end
    end

    assign reg_rdata_out = rdata_q;
    assign ack_out = ack_q;
    assign nak_out = nak_q;
    assign mem_we_out = mem_we_q;
    assign mem_addr_out = mem_addr_q;
    assign mem_data_out = mem_data_q;
    assign buffer_full_out = full_out_q;
    assign iso_mode_out = iso_out_q;
    assign x_start_out = x_start_q;
    assign y_start_out = y_start_q;
    assign irq_out = irq_q;

endmodule

// *** common/uoxb_consts.vh ***
// Purpose: constants for the OUT endpoint X buffer descriptor logic
// Assumes: one 10 MHz clock, asynchronous active-high reset
// Notes: register indices are byte offsets on the 3-bit register port
`ifndef UOXB_CONSTS_VH
`define UOXB_CONSTS_VH

// register indices
`define UOXB_REG_CONFIG 3'h0
`define UOXB_REG_COUNT_STATUS 3'h1
`define UOXB_REG_BUFFER_SIZE 3'h2
`define UOXB_REG_X_BASE 3'h3
`define UOXB_REG_Y_BASE 3'h4
`define UOXB_REG_INT_STATUS 3'h5
`define UOXB_REG_INT_MASK 3'h6

// field positions
`define UOXB_FULL_BIT 7
`define UOXB_ISO_BIT 6
`define UOXB_BPS_MSB 1
`define UOXB_BPS_LSB 0
`define UOXB_INT_RX_BIT 0
`define UOXB_INT_NAK_BIT 1

// reset values and fills
`define UOXB_RST_BYTE 8'h00
`define UOXB_LOW_ZERO 3'h0

// receive states
`define UOXB_ST_IDLE 2'h0
`define UOXB_ST_RECV 2'h1
`define UOXB_ST_DROP 2'h2

`endif

// *** tb/uoxb_ctrl_asserts.sv ***
// Purpose: port checker for the OUT endpoint X buffer control
// Assumes: one clock, reset high
// Notes: sees only the ports of uoxb_ctrl
`include "uoxb_consts.vh"

module uoxb_ctrl_asserts #(
    parameter ADDR_W = 11
) (
    input wire ref_clk_in,
    input wire rst_in,
    input wire [2:0] reg_addr_in,
    input wire [7:0] reg_wdata_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    input wire [7:0] reg_rdata_out,
    input wire pkt_start_in,
    input wire byte_valid_in,
    input wire [7:0] byte_in,
    input wire pkt_ok_in,
    input wire pkt_err_in,
    input wire ack_out,
    input wire nak_out,
    input wire mem_we_out,
    input wire [ADDR_W-1:0] mem_addr_out,
    input wire [7:0] mem_data_out,
    input wire buffer_full_out,
    input wire iso_mode_out,
    input wire [ADDR_W-1:0] x_start_out,
    input wire [ADDR_W-1:0] y_start_out,
    input wire irq_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (rst_in);

    AST_ACK_SETS_FLAG: assert property (ack_out |=> buffer_full_out)
        else $error("flag not set after ack");
    AST_ACK_FROM_OK: assert property (ack_out |-> $past(pkt_ok_in))
        else $error("ack without good end");
    AST_NO_ACK_FULL: assert property (ack_out |-> !buffer_full_out)
        else $error("ack while full");
    AST_NAK_CAUSE: assert property (nak_out |-> $past(pkt_ok_in || pkt_err_in))
        else $error("nak without packet end");
    AST_ISO_SILENT: assert property (iso_mode_out && $past(iso_mode_out) |-> !ack_out && !nak_out)
        else $error("handshake in iso mode");
    AST_FLAG_SW_CLEAR: assert property ($fell(buffer_full_out) |->
        $past(reg_wr_in, 2) && $past(reg_addr_in, 2) == `UOXB_REG_COUNT_STATUS)
        else $error("flag dropped by itself");
    AST_X_LOW_ZERO: assert property (x_start_out[2:0] == 3'h0)
        else $error("x start low bits set");
    AST_X_START_WR: assert property (reg_wr_in && reg_addr_in == `UOXB_REG_X_BASE |->
        ##2 x_start_out == {$past(reg_wdata_in, 2), 3'h0})
        else $error("x start not from base");
    AST_Y_START_WR: assert property (reg_wr_in && reg_addr_in == `UOXB_REG_Y_BASE |->
        ##2 y_start_out == {$past(reg_wdata_in, 2), 3'h0})
        else $error("y start not from base");
    AST_MEM_DATA: assert property (mem_we_out |->
        $past(byte_valid_in) && mem_data_out == $past(byte_in))
        else $error("write without byte");
    AST_MEM_FIRST: assert property ($past(pkt_start_in, 2) && mem_we_out && !iso_mode_out |->
        mem_addr_out == x_start_out)
        else $error("first byte off start");
    AST_MEM_CONSEC: assert property (mem_we_out && $past(mem_we_out) && !iso_mode_out |->
        mem_addr_out == $past(mem_addr_out) + 1'b1)
        else $error("write address skipped");
    AST_RDATA_IDLE: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
        else $error("read data outside slot");

    cover property (ack_out);
    cover property (nak_out);
    cover property (mem_we_out && iso_mode_out);
    cover property (irq_out);
endmodule

// *** tb/uoxb_host_model.sv ***
// Purpose: host side sending OUT data packets
// Assumes: strobes change just after a rising edge
// Notes: idle byte lane shows the inverse of the last byte
module uoxb_host_model (
    // clock
    input wire ref_clk_in,
    // packet side
    output logic start_out = 1'b0,
    output logic valid_out = 1'b0,
    output wire [7:0] byte_out,
    output logic ok_out = 1'b0,
    output logic err_out = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] lane_q = 8'h5A;

    // stale data must never look like a valid byte
    assign byte_out = valid_out ? lane_q : ~lane_q;

    task automatic send(input int n, input bit err);
        @(posedge ref_clk_in);
        start_out <= 1'b1;
        for (int i = 0; i < n; i++)
        begin
            @(posedge ref_clk_in);
            start_out <= 1'b0;
            valid_out <= 1'b1;
            lane_q <= 8'hC0 + 8'(i);
        end
        @(posedge ref_clk_in);
        start_out <= 1'b0;
        valid_out <= 1'b0;
        ok_out <= !err;
        err_out <= err;
        @(posedge ref_clk_in);
        ok_out <= 1'b0;
        err_out <= 1'b0;
    endtask
endmodule

// *** tb/tb_uoxb_ctrl.sv ***
// Purpose: self-checking bench for the OUT endpoint X buffer control
// Assumes: bench plays the processor, host model the packet side
// Notes: handshake and write pulses are tallied by counters
`include "uoxb_consts.vh"

module tb_uoxb_ctrl;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [2:0] reg_addr_in = 3'h0;
    logic [7:0] reg_wdata_in = 8'h00;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    wire [7:0] reg_rdata_out;
    wire pkt_start_in, byte_valid_in, pkt_ok_in, pkt_err_in;
    wire [7:0] byte_in;
    wire ack_out, nak_out, mem_we_out, buffer_full_out, iso_mode_out, irq_out;
    wire [10:0] mem_addr_out, x_start_out, y_start_out;
    wire [7:0] mem_data_out;
    int fail_count = 0;
    int n_compared = 0;
    int ack_n = 0;
    int nak_n = 0;
    int we_n = 0;
    // last buffer write, to check where the bytes landed
    logic [10:0] wa_last = 11'h000;
    logic [7:0] wd_last = 8'h00;

    always #50 ref_clk_in = ~ref_clk_in;

    uoxb_ctrl uoxb_ctrl_i (.*);
    uoxb_host_model uoxb_host_model_i (
        .ref_clk_in(ref_clk_in),
        .start_out(pkt_start_in),
        .valid_out(byte_valid_in),
        .byte_out(byte_in),
        .ok_out(pkt_ok_in),
        .err_out(pkt_err_in)
    );

    always @(posedge ref_clk_in)
    begin
        ack_n += (ack_out === 1'b1);
        nak_n += (nak_out === 1'b1);
        we_n += (mem_we_out === 1'b1);
        if (mem_we_out === 1'b1)
        begin
            wa_last = mem_addr_out;
            wd_last = mem_data_out;
        end
    end

    task automatic chk(input string nm, input logic [10:0] got, input logic [10:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge ref_clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge ref_clk_in);
        reg_wr_in <= 1'b0;
    endtask

    task automatic rd_chk(input logic [2:0] a, input logic [7:0] e, input string nm);
        @(posedge ref_clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge ref_clk_in);
        reg_rd_in <= 1'b0;
        #1 chk(nm, reg_rdata_out, e);
    endtask

    // one packet, then handshake and write tallies and the count byte
    task automatic pkt(input int n, input bit err, input int da, input int dn, input int dw,
        input logic [7:0] cnt);
        int a0;
        int n0;
        int w0;
        a0 = ack_n;
        n0 = nak_n;
        w0 = we_n;
        uoxb_host_model_i.send(n, err);
        repeat (3) @(posedge ref_clk_in);
        chk("acks", 11'(ack_n - a0), 11'(da));
        chk("naks", 11'(nak_n - n0), 11'(dn));
        chk("writes", 11'(we_n - w0), 11'(dw));
        rd_chk(`UOXB_REG_COUNT_STATUS, cnt, "count byte");
    endtask

    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial
    begin
        repeat (3000) @(posedge ref_clk_in);
        fail_count++;
        finish_test();
    end

    initial
    begin
        repeat (3) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        wr(3'h7, 8'hFF);
        for (int a = 0; a < 8; a++)
            rd_chk(3'(a), 8'h00, "reset value");
        wr(`UOXB_REG_BUFFER_SIZE, 8'h01);
        wr(`UOXB_REG_X_BASE, 8'hA5);
        wr(`UOXB_REG_Y_BASE, 8'h3C);
        wr(`UOXB_REG_INT_MASK, 8'h01);
        rd_chk(`UOXB_REG_X_BASE, 8'hA5, "x base");
        chk("x start", x_start_out, 11'h528);
        chk("y start", y_start_out, 11'h1E0);
        pkt(3, 1'b0, 1, 0, 3, 8'h83);
        chk("last addr", wa_last, 11'h52A);
        chk("last data", wd_last, 8'hC2);
        chk("irq raised", irq_out, 1'b1);
        rd_chk(`UOXB_REG_INT_STATUS, 8'h01, "status rx");
        rd_chk(`UOXB_REG_INT_STATUS, 8'h00, "status cleared");
        chk("irq cleared", irq_out, 1'b0);
        pkt(2, 1'b0, 0, 1, 0, 8'h83);
        chk("full out", buffer_full_out, 1'b1);
        chk("irq masked", irq_out, 1'b0);
        rd_chk(`UOXB_REG_INT_STATUS, 8'h02, "status nak");
        wr(`UOXB_REG_COUNT_STATUS, 8'h00);
        pkt(10, 1'b0, 1, 0, 8, 8'h8A);
        chk("capped addr", wa_last, 11'h52F);
        // flag left set: iso must still take every packet
        for (int b = 0; b < 4; b++)
        begin
            wr(`UOXB_REG_CONFIG, 8'h40 | 8'(b));
            pkt(12, 1'b0, 0, 0, 12, 8'h80 | 8'(12 / (b + 1)));
            chk("ring addr", wa_last, 11'h52B);
            chk("ring data", wd_last, 8'hCB);
            chk("iso out", iso_mode_out, 1'b1);
        end
        wr(`UOXB_REG_COUNT_STATUS, 8'h00);
        rd_chk(`UOXB_REG_COUNT_STATUS, 8'h00, "flag cleared");
        wr(`UOXB_REG_CONFIG, 8'h00);
        pkt(4, 1'b1, 0, 0, 4, 8'h00);
        finish_test();
    end
endmodule

bind uoxb_ctrl uoxb_ctrl_asserts #(.ADDR_W(ADDR_W)) uoxb_ctrl_asserts_i (.*);
